// file: design/tmo_pkg.sv
package tmo_pkg;
	// ------------------------------------------------
	// register map
	// ------------------------------------------------
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [2:0] OFS_CONTROL = 3'h0;
	localparam logic [2:0] OFS_COUNT_LOW = 3'h1;
	localparam logic [2:0] OFS_COUNT_HIGH = 3'h2;
	localparam logic [2:0] OFS_IRQ_STATUS = 3'h3;
	localparam logic [2:0] OFS_IRQ_MASK = 3'h4;

	// ------------------------------------------------
	// control and interrupt register fields
	// ------------------------------------------------
	localparam int BIT_COUNTER_ON = 0;
	localparam int BIT_SOURCE_SELECT = 1;
	localparam int BIT_SYNC_BYPASS = 2;
	localparam int BIT_OSC_ENABLE = 3;
	localparam int PS_LO = 4;
	localparam int PS_HI = 5;
	localparam int BIT_CLOCK_STATUS = 6;
	localparam int BIT_WIDE_ACCESS = 7;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONTROL_WMASK = 8'hBF;
	localparam int BIT_OVERFLOW = 0;
	localparam logic [7:0] IRQ_RESET = 8'h00;

	// ------------------------------------------------
	// counter and timing
	// ------------------------------------------------
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam int FOSC_PER_INSTR = 4;
	localparam logic [1:0] INSTR_LAST = 2'(FOSC_PER_INSTR - 1);

	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] count;
		logic [7:0] hbuf;
		logic [2:0] pre;
		logic [1:0] phase;
		logic [2:0] pin_s;
		logic [2:0] osc_s;
		logic [2:0] clk_s;
		logic pin_lvl;
		logic osc_lvl;
		logic clk_lvl;
		logic prev_src;
		logic edge_pend;
		logic [7:0] status;
		logic [7:0] mask;
		logic [7:0] rdata;
		logic irq;
		logic pins_in;
	} tmo_state_s;
endpackage : tmo_pkg

// file: design/tmo_timer.sv
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module tmo_timer (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic [tmo_pkg::ADDR_W-1:0] addr,
	input wire logic [tmo_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [tmo_pkg::DATA_W-1:0] rdata,
	// pins and clock control
	input wire logic external_count_pin,
	input wire logic osc_input_pin,
	input wire logic system_clock_from_timer_osc,
	output logic timer_osc_enable,
	output logic clock_pins_as_input,
	output logic port_read_zero,
	// interrupt
	output logic irq
);
	import tmo_pkg::*;

	tmo_state_s s;
	tmo_state_s next_s;
	logic tick;
	logic src_lvl;
	logic ext_rise;
	logic cnt_ev;
	logic inc;
	logic set_ovf;
	logic rd_clear;
	logic [2:0] ps_mask;

	// ------------------------------------------------
	// decoding helpers
	// ------------------------------------------------
	function automatic logic hit(input logic strobe, input logic [2:0] a,
		input logic [2:0] ofs);
		hit = strobe && (a == ofs);
	endfunction : hit

	function automatic logic [2:0] prescale_mask(input logic [1:0] sel);
		case (sel)
			2'h0: prescale_mask = 3'h0;
			2'h1: prescale_mask = 3'h1;
			2'h2: prescale_mask = 3'h3;
			default: prescale_mask = 3'h7;
		endcase
	endfunction : prescale_mask

	// ------------------------------------------------
	// next state
	// ------------------------------------------------
	always_comb begin
		next_s = s;
		// three-stage pin synchronisers, level taken when stages 2 and 3 agree
		next_s.pin_s = {s.pin_s[1:0], external_count_pin};
		next_s.osc_s = {s.osc_s[1:0], osc_input_pin};
		next_s.clk_s = {s.clk_s[1:0], system_clock_from_timer_osc};
		if (s.pin_s[1] == s.pin_s[2]) begin
			next_s.pin_lvl = s.pin_s[2];
		end
		if (s.osc_s[1] == s.osc_s[2]) begin
			next_s.osc_lvl = s.osc_s[2];
		end
		if (s.clk_s[1] == s.clk_s[2]) begin
			next_s.clk_lvl = s.clk_s[2];
		end

		// instruction cycle is four device clocks
		next_s.phase = s.phase + 2'h1;
		tick = (s.phase == INSTR_LAST);

		// oscillator replaces the pin as edge source when enabled
		src_lvl = s.ctrl[BIT_OSC_ENABLE] ? s.osc_lvl : s.pin_lvl;
		ext_rise = src_lvl && !s.prev_src;
		next_s.prev_src = src_lvl;

		cnt_ev = 1'b0;
		if (!s.ctrl[BIT_SOURCE_SELECT]) begin
			cnt_ev = tick;
			next_s.edge_pend = 1'b0;
		end else if (s.ctrl[BIT_SYNC_BYPASS]) begin
			cnt_ev = ext_rise;
			next_s.edge_pend = 1'b0;
		end else begin
			// synchronised: hold the edge until the instruction boundary
			next_s.edge_pend = s.edge_pend || ext_rise;
			if (tick) begin
				cnt_ev = s.edge_pend || ext_rise;
				next_s.edge_pend = 1'b0;
			end
		end
		if (!s.ctrl[BIT_COUNTER_ON]) begin
			cnt_ev = 1'b0;
			next_s.edge_pend = 1'b0;
		end

		// prescaler passes one event in 1, 2, 4 or 8
		ps_mask = prescale_mask(s.ctrl[PS_HI:PS_LO]);
		inc = 1'b0;
		if (cnt_ev) begin
			if ((s.pre & ps_mask) == ps_mask) begin
				inc = 1'b1;
				next_s.pre = 3'h0;
			end else begin
				next_s.pre = s.pre + 3'h1;
			end
		end
		set_ovf = 1'b0;
		if (inc) begin
			next_s.count = s.count + 16'h0001;
			set_ovf = (s.count == COUNT_MAX);
		end

		// register writes win over a coincident increment
		if (hit(wr, addr, OFS_CONTROL)) begin
			next_s.ctrl = (wdata & CONTROL_WMASK) | (s.ctrl & ~CONTROL_WMASK);
		end
		if (hit(wr, addr, OFS_COUNT_LOW)) begin
			next_s.count[7:0] = wdata;
			next_s.pre = 3'h0;
			if (s.ctrl[BIT_WIDE_ACCESS]) begin
				next_s.count[15:8] = s.hbuf;
			end
		end
		if (hit(wr, addr, OFS_COUNT_HIGH)) begin
			if (s.ctrl[BIT_WIDE_ACCESS]) begin
				next_s.hbuf = wdata;
			end else begin
				next_s.count[15:8] = wdata;
			end
		end
		if (hit(wr, addr, OFS_IRQ_MASK)) begin
			next_s.mask = {7'h00, wdata[BIT_OVERFLOW]};
		end
		next_s.ctrl[BIT_CLOCK_STATUS] = s.clk_lvl;

		// reads, answered in the following cycle
		next_s.rdata = 8'h00;
		rd_clear = 1'b0;
		if (rd) begin
			case (addr)
				OFS_CONTROL: next_s.rdata = s.ctrl;
				OFS_COUNT_LOW: begin
					next_s.rdata = s.count[7:0];
					if (s.ctrl[BIT_WIDE_ACCESS]) begin
						next_s.hbuf = s.count[15:8];
					end
				end
				OFS_COUNT_HIGH: begin
					next_s.rdata = s.ctrl[BIT_WIDE_ACCESS] ? s.hbuf
						: s.count[15:8];
				end
				OFS_IRQ_STATUS: begin
					next_s.rdata = s.status;
					rd_clear = 1'b1;
				end
				OFS_IRQ_MASK: next_s.rdata = s.mask;
				default: next_s.rdata = 8'h00;
			endcase
		end

		// sticky overflow: a new event beats a clearing read
		next_s.status[BIT_OVERFLOW] = (s.status[BIT_OVERFLOW] && !rd_clear)
			|| set_ovf;
		next_s.irq = |(next_s.status & next_s.mask);
		next_s.pins_in = next_s.ctrl[BIT_COUNTER_ON];
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s <= '0;
			s.ctrl <= CONTROL_RESET;
			s.count <= COUNT_RESET;
			s.status <= IRQ_RESET;
			s.mask <= IRQ_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------
	// outputs
	// ------------------------------------------------
	assign rdata = s.rdata;
	assign irq = s.irq;
	// oscillator enable has no power-mode term, so it runs through all
	assign timer_osc_enable = s.ctrl[BIT_OSC_ENABLE];
	assign clock_pins_as_input = s.pins_in;
	assign port_read_zero = s.pins_in;

	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_off_holds;
		!s.ctrl[BIT_COUNTER_ON] && !hit(wr, addr, OFS_COUNT_LOW)
			&& !hit(wr, addr, OFS_COUNT_HIGH)
			|=> $stable(s.count) && $stable(s.pre);
	endproperty
	a_off_holds: assert property (p_off_holds)
		else $error("count moved while stopped");

	property p_internal_rate;
		s.ctrl[BIT_COUNTER_ON] && !s.ctrl[BIT_SOURCE_SELECT]
			&& s.ctrl[PS_HI:PS_LO] == 2'h0 && tick && !wr
			|=> s.count == $past(s.count) + 16'h0001 ##1 $stable(s.count)[*3];
	endproperty
	a_internal_rate: assert property (p_internal_rate)
		else $error("internal count not once per instruction cycle");

	property p_wrap_flag;
		inc && s.count == COUNT_MAX && !wr
			|=> s.count == 16'h0000 && s.status[BIT_OVERFLOW]
			&& irq == s.mask[BIT_OVERFLOW];
	endproperty
	a_wrap_flag: assert property (p_wrap_flag)
		else $error("wrap did not set overflow");

	property p_latch_high;
		hit(rd, addr, OFS_COUNT_LOW) && s.ctrl[BIT_WIDE_ACCESS]
			|=> s.hbuf == $past(s.count[15:8]) && rdata == $past(s.count[7:0]);
	endproperty
	a_latch_high: assert property (p_latch_high)
		else $error("low read did not latch high byte");

	property p_wide_write;
		hit(wr, addr, OFS_COUNT_LOW) && s.ctrl[BIT_WIDE_ACCESS]
			|=> s.count == {$past(s.hbuf), $past(wdata)} && s.pre == 3'h0;
	endproperty
	a_wide_write: assert property (p_wide_write)
		else $error("wide write not applied as a whole");

	property p_high_buffered;
		hit(wr, addr, OFS_COUNT_HIGH) && s.ctrl[BIT_WIDE_ACCESS] && !inc
			|=> $stable(s.count) && s.hbuf == $past(wdata);
	endproperty
	a_high_buffered: assert property (p_high_buffered)
		else $error("live high byte written directly");

	property p_high_keeps_pre;
		hit(wr, addr, OFS_COUNT_HIGH) && !cnt_ev |=> $stable(s.pre);
	endproperty
	a_high_keeps_pre: assert property (p_high_keeps_pre)
		else $error("high byte write touched prescaler");

	property p_prescale_eight;
		cnt_ev && s.ctrl[PS_HI:PS_LO] == 2'h3 && s.pre != 3'h7 |-> !inc;
	endproperty
	a_prescale_eight: assert property (p_prescale_eight)
		else $error("prescale 1:8 passed early");

	property p_clock_status;
		##1 s.ctrl[BIT_CLOCK_STATUS] == $past(s.clk_lvl);
	endproperty
	a_clock_status: assert property (p_clock_status)
		else $error("clock status bit does not track source");

	property p_pins_input;
		s.ctrl[BIT_COUNTER_ON] |-> clock_pins_as_input && port_read_zero;
	endproperty
	a_pins_input: assert property (p_pins_input)
		else $error("clock pins not inputs while enabled");

	property p_narrow_high;
		hit(wr, addr, OFS_COUNT_HIGH) && !s.ctrl[BIT_WIDE_ACCESS]
			|=> s.count[15:8] == $past(wdata);
	endproperty
	a_narrow_high: assert property (p_narrow_high)
		else $error("narrow high write missed the count");

	property p_off_write;
		!s.ctrl[BIT_COUNTER_ON] && hit(wr, addr, OFS_COUNT_LOW)
			|=> s.count[7:0] == $past(wdata) && s.pre == 3'h0;
	endproperty
	a_off_write: assert property (p_off_write)
		else $error("count write lost while stopped");

	property p_flag_sticky;
		s.status[BIT_OVERFLOW] && !hit(rd, addr, OFS_IRQ_STATUS)
			|=> s.status[BIT_OVERFLOW];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("overflow flag dropped without a read");

	property p_flag_clear;
		hit(rd, addr, OFS_IRQ_STATUS) && !set_ovf
			|=> !s.status[BIT_OVERFLOW] && !irq;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("status read did not clear overflow");

	property p_ctrl_write;
		hit(wr, addr, OFS_CONTROL)
			|=> timer_osc_enable == $past(wdata[BIT_OSC_ENABLE])
			&& clock_pins_as_input == $past(wdata[BIT_COUNTER_ON]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write not seen on the pins");

	property p_sync_waits;
		s.ctrl[BIT_COUNTER_ON] && s.ctrl[BIT_SOURCE_SELECT]
			&& !s.ctrl[BIT_SYNC_BYPASS] && !tick |-> !cnt_ev;
	endproperty
	a_sync_waits: assert property (p_sync_waits)
		else $error("synchronised edge counted off the boundary");

	property p_bypass_now;
		s.ctrl[BIT_COUNTER_ON] && s.ctrl[BIT_SOURCE_SELECT]
			&& s.ctrl[BIT_SYNC_BYPASS] && ext_rise |-> cnt_ev;
	endproperty
	a_bypass_now: assert property (p_bypass_now)
		else $error("unsynchronised edge not counted at once");

	c_wrap: cover property (inc && s.count == COUNT_MAX);
	c_wide_read: cover property (hit(rd, addr, OFS_COUNT_LOW)
		&& s.ctrl[BIT_WIDE_ACCESS]);
	c_ext_count: cover property (inc && s.ctrl[BIT_SOURCE_SELECT]);
	c_wide_write: cover property (hit(wr, addr, OFS_COUNT_LOW)
		&& s.ctrl[BIT_WIDE_ACCESS]);
	c_sync_edge: cover property (cnt_ev && s.ctrl[BIT_SOURCE_SELECT]
		&& !s.ctrl[BIT_SYNC_BYPASS]);
endmodule : tmo_timer

// file: tb/tmo_ext_src.sv
`timescale 1ns/10ps
module tmo_ext_src #(
	parameter int OSC_HALF_NS = 40,
	parameter int START_NS = 400
) (
	// oscillator control
	input wire logic timer_osc_enable,
	// clock lines
	output logic external_count_pin,
	output logic osc_input_pin
);
	initial begin
		external_count_pin = 1'b0;
		osc_input_pin = 1'b0;
	end

	// ----
	// crystal: silent until enabled, then starts up slowly
	// ----
	always begin
		wait (timer_osc_enable === 1'b1);
		#(START_NS);
		// keep every crystal edge off the device clock edge
		#1;
		while (timer_osc_enable === 1'b1) begin
			#(OSC_HALF_NS) osc_input_pin = ~osc_input_pin;
		end
		osc_input_pin = 1'b0;
	end

	task pin_pulses(input int n, input int half_ns);
		#1;
		repeat (n) begin
			#(half_ns) external_count_pin = 1'b1;
			#(half_ns) external_count_pin = 1'b0;
		end
	endtask : pin_pulses
endmodule : tmo_ext_src

// file: tb/tmo_timer_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
n_mismatch++; $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module tmo_timer_tb;
	import tmo_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic system_clock_from_timer_osc = 1'b0;
	logic [7:0] rdata;
	logic external_count_pin;
	logic osc_input_pin;
	logic timer_osc_enable;
	logic clock_pins_as_input;
	logic port_read_zero;
	logic irq;
	int n_mismatch = 0;
	int num_checks = 0;
	logic [7:0] d;
	logic [15:0] c;
	logic [15:0] c2;
	int k;

	tmo_timer tmo_timer_inst (.clk(clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.external_count_pin(external_count_pin), .osc_input_pin(osc_input_pin),
		.system_clock_from_timer_osc(system_clock_from_timer_osc),
		.timer_osc_enable(timer_osc_enable),
		.clock_pins_as_input(clock_pins_as_input),
		.port_read_zero(port_read_zero), .irq(irq));
	tmo_ext_src tmo_ext_src_inst (.timer_osc_enable(timer_osc_enable),
		.external_count_pin(external_count_pin), .osc_input_pin(osc_input_pin));

	always #2 clk = ~clk;

	// ----
	// register port access
	// ----
	task wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg

	task rd_cnt(output logic [15:0] v);
		logic [7:0] lo;
		logic [7:0] hi;
		rd_reg(OFS_COUNT_LOW, lo);
		rd_reg(OFS_COUNT_HIGH, hi);
		v = {hi, lo};
	endtask : rd_cnt

	task set_cnt(input logic [15:0] v);
		wr_reg(OFS_COUNT_HIGH, v[15:8]);
		wr_reg(OFS_COUNT_LOW, v[7:0]);
	endtask : set_cnt

	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		for (k = 0; k < 5; k++) begin
			rd_reg(3'(k), d);
			`CHK("reset_value", 8'h00, d)
		end
		wr_reg(OFS_CONTROL, 8'hFF);
		rd_reg(OFS_CONTROL, d);
		`CHK("control", 8'hBF, d)
		@(posedge clk);
		system_clock_from_timer_osc <= 1'b1;
		// three sync stages and the status register lag the pin
		repeat (5) @(posedge clk);
		rd_reg(OFS_CONTROL, d);
		`CHK("control", 8'hFF, d)
		@(posedge clk);
		system_clock_from_timer_osc <= 1'b0;
		repeat (5) @(posedge clk);
		rd_reg(OFS_CONTROL, d);
		`CHK("control", 8'hBF, d)
		wr_reg(3'h7, 8'hA5);
		rd_reg(3'h7, d);
		`CHK("unmapped", 8'h00, d)
		wr_reg(OFS_CONTROL, 8'h00);
		// internal ticks at every prescale
		for (k = 0; k < 4; k++) begin
			set_cnt(16'h0000);
			wr_reg(OFS_CONTROL, {2'h0, 2'(k), 4'h1});
			repeat (40 << k) @(posedge clk);
			wr_reg(OFS_CONTROL, 8'h00);
			rd_cnt(c);
			`CHK("tick_count", 1'b1, (c >= 16'h0009 && c <= 16'h000B))
			repeat (50) @(posedge clk);
			rd_cnt(c2);
			`CHK("halted_count", c, c2)
		end
		// pin edges, synchronised then not
		for (k = 0; k < 2; k++) begin
			set_cnt(16'h0000);
			wr_reg(OFS_CONTROL, {5'h00, 1'(k), 2'h3});
			tmo_ext_src_inst.pin_pulses(5, 40);
			repeat (20) @(posedge clk);
			wr_reg(OFS_CONTROL, 8'h00);
			rd_cnt(c);
			`CHK("pin_edges", 16'h0005, c)
		end
		// crystal counting
		set_cnt(16'h0000);
		wr_reg(OFS_CONTROL, 8'h0B);
		repeat (2) @(posedge clk);
		#1;
		`CHK("osc_enable", 1'b1, timer_osc_enable)
		`CHK("pins_input", 1'b1, clock_pins_as_input)
		`CHK("read_zero", 1'b1, port_read_zero)
		repeat (500) @(posedge clk);
		wr_reg(OFS_CONTROL, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		`CHK("osc_enable", 1'b0, timer_osc_enable)
		`CHK("pins_input", 1'b0, clock_pins_as_input)
		`CHK("read_zero", 1'b0, port_read_zero)
		rd_cnt(c);
		`CHK("osc_count", 1'b1, (c >= 16'h000F && c <= 16'h0019))
		// buffered wide access
		wr_reg(OFS_CONTROL, 8'h80);
		set_cnt(16'h1234);
		wr_reg(OFS_COUNT_HIGH, 8'h56);
		wr_reg(OFS_CONTROL, 8'h00);
		rd_cnt(c);
		`CHK("wide_write", 16'h1234, c)
		wr_reg(OFS_COUNT_HIGH, 8'h9A);
		wr_reg(OFS_CONTROL, 8'h80);
		rd_reg(OFS_COUNT_HIGH, d);
		`CHK("high_buffer", 8'h56, d)
		rd_reg(OFS_COUNT_LOW, d);
		`CHK("low_byte", 8'h34, d)
		rd_reg(OFS_COUNT_HIGH, d);
		`CHK("high_latched", 8'h9A, d)
		wr_reg(OFS_CONTROL, 8'h00);
		// wrap with interrupt unmasked, then masked
		for (k = 1; k >= 0; k--) begin
			wr_reg(OFS_IRQ_MASK, 8'(k));
			set_cnt(16'hFFFE);
			wr_reg(OFS_CONTROL, 8'h01);
			for (int i = 0; i < 40 && irq !== 1'b1; i++) begin
				@(posedge clk);
				#1;
			end
			`CHK("irq", 1'(k), irq)
			wr_reg(OFS_CONTROL, 8'h00);
			rd_cnt(c);
			`CHK("wrapped", 1'b1, (c < 16'h0010))
			rd_reg(OFS_IRQ_STATUS, d);
			`CHK("status", 8'h01, d)
			@(posedge clk);
			#1;
			`CHK("irq_clear", 1'b0, irq)
			rd_reg(OFS_IRQ_STATUS, d);
			`CHK("status_clear", 8'h00, d)
		end
		complete_run();
	end
endmodule : tmo_timer_tb
